// *** rtl/pg_monitor_pkg.sv ***
package pg_monitor_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned reg_addr_w = 8;
    localparam int unsigned reg_data_w = 8;
    localparam logic [7:0] power_good_control_offset = 8'h13;
    localparam logic [7:0] monitor_one_levels_offset = 8'h14;
    localparam logic [7:0] reg_reset_value = 8'h00;

    // Writable bits; reserved bits are masked to zero
    localparam logic [7:0] power_good_control_mask = 8'h7f;
    localparam logic [7:0] monitor_one_levels_mask = 8'h1f;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int unsigned n_sources = 6;
    localparam int unsigned check_method_bit = 6;
    localparam int unsigned analog_supply_bit = 5;
    localparam int unsigned monitor_two_bit = 4;
    localparam int unsigned monitor_one_bit = 3;
    localparam int unsigned boost_bit = 2;
    localparam int unsigned second_buck_bit = 1;
    localparam int unsigned first_buck_bit = 0;
    localparam int unsigned tolerance_lsb = 3;
    localparam int unsigned tolerance_w = 2;
    localparam int unsigned level_lsb = 0;
    localparam int unsigned level_w = 3;

    // Level code that leaves the input high-impedance (external divider)
    localparam logic [2:0] level_external_divider = 3'h0;

    // Tolerance codes: 2, 3, 4 and 6 percent
    typedef enum logic [1:0] {
        tol_2pct = 2'b00,
        tol_3pct = 2'b01,
        tol_4pct = 2'b10,
        tol_6pct = 2'b11
    } tolerance_t;

    // Configuration life cycle
    typedef enum logic [0:0] {
        cfg_load_otp = 1'b0,
        cfg_run = 1'b1
    } cfg_state_t;

endpackage : pg_monitor_pkg

// *** rtl/pg_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module pg_monitor #(
    parameter int unsigned addr_w = 8 // Register address width
) (
    input wire logic i_core_clk, // 10 MHz core clock
    input wire logic i_reset, // Async reset, active high
    input wire logic [addr_w-1:0] i_reg_addr, // Register address
    input wire logic [pg_monitor_pkg::reg_data_w-1:0] i_reg_wdata, // Write data
    input wire logic i_reg_wr, // Write strobe
    input wire logic i_reg_rd, // Read strobe
    output logic [pg_monitor_pkg::reg_data_w-1:0] o_reg_rdata, // Read data, next cycle
    input wire logic [7:0] i_otp_control_default, // One-time memory control default
    input wire logic [7:0] i_otp_levels_default, // One-time memory levels default
    input wire logic [pg_monitor_pkg::n_sources-1:0] i_uv_flags, // Undervoltage comparators
    input wire logic [pg_monitor_pkg::n_sources-1:0] i_ov_flags, // Overvoltage comparators
    output logic o_power_good_out_a, // Power good A, high when good
    output logic o_power_good_out_b, // Power good B, high when good
    output logic o_fault_event, // One-cycle pulse on new fault
    output logic [pg_monitor_pkg::tolerance_w-1:0] o_monitor_one_tolerance, // Window code
    output logic [pg_monitor_pkg::level_w-1:0] o_monitor_one_level, // Threshold code
    output logic o_monitor_one_divider_en // Internal divider on
);
    import pg_monitor_pkg::*;

    localparam int unsigned n = n_sources;

    // Address must reach both register offsets
    if (addr_w < 5) begin : g_bad_addr_w
        $error("pg_monitor: addr_w too small for register map");
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hits(input logic [addr_w-1:0] a, input logic [7:0] off);
        hits = (a == addr_w'(off));
    endfunction : hits

    cfg_state_t state_r;
    logic [7:0] ctrl_r;
    logic [7:0] level_r;
    logic [n-1:0] uv_s1_r, uv_s2_r, uv_s3_r, uv_flt_r;
    logic [n-1:0] ov_s1_r, ov_s2_r, ov_s3_r, ov_flt_r;
    logic [n-1:0] fault_r;
    logic [n-1:0] enable_vec;
    logic [n-1:0] fault_nxt;
    logic check_method_select;
    logic analog_supply_check_enable;
    logic monitor_two_check_enable;
    logic monitor_one_check_enable;
    logic boost_check_enable;
    logic second_buck_check_enable;
    logic first_buck_check_enable;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // One load cycle after reset; a write in that cycle is dropped
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= cfg_load_otp;
        end else begin
            state_r <= cfg_run;
        end
    end

    // Defaults cannot be a reset constant, so they load after release
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r <= reg_reset_value;
            level_r <= reg_reset_value;
        end else if (state_r == cfg_load_otp) begin
            ctrl_r <= i_otp_control_default & power_good_control_mask;
            level_r <= i_otp_levels_default & monitor_one_levels_mask;
        end else if (i_reg_wr) begin
            if (hits(i_reg_addr, power_good_control_offset)) begin
                ctrl_r <= i_reg_wdata & power_good_control_mask;
            end
            if (hits(i_reg_addr, monitor_one_levels_offset)) begin
                level_r <= i_reg_wdata & monitor_one_levels_mask;
            end
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= reg_reset_value;
        end else if (i_reg_rd) begin
            if (hits(i_reg_addr, power_good_control_offset)) begin
                o_reg_rdata <= ctrl_r;
            end else if (hits(i_reg_addr, monitor_one_levels_offset)) begin
                o_reg_rdata <= level_r;
            end else begin
                o_reg_rdata <= reg_reset_value;
            end
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    // method select
    assign check_method_select = ctrl_r[check_method_bit];
    assign analog_supply_check_enable = ctrl_r[analog_supply_bit];
    assign monitor_two_check_enable = ctrl_r[monitor_two_bit];
    assign monitor_one_check_enable = ctrl_r[monitor_one_bit];
    assign boost_check_enable = ctrl_r[boost_bit];
    assign second_buck_check_enable = ctrl_r[second_buck_bit];
    assign first_buck_check_enable = ctrl_r[first_buck_bit];
    assign enable_vec = {analog_supply_check_enable, monitor_two_check_enable,
                         monitor_one_check_enable, boost_check_enable,
                         second_buck_check_enable, first_buck_check_enable};

    // ----------------------------------------------------------------
    // Comparator input filtering
    // ----------------------------------------------------------------
    // Three stages; a change counts only once stages two and three agree
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            uv_s1_r <= '0;
            uv_s2_r <= '0;
            uv_s3_r <= '0;
            ov_s1_r <= '0;
            ov_s2_r <= '0;
            ov_s3_r <= '0;
        end else begin
            uv_s1_r <= i_uv_flags;
            uv_s2_r <= uv_s1_r;
            uv_s3_r <= uv_s2_r;
            ov_s1_r <= i_ov_flags;
            ov_s2_r <= ov_s1_r;
            ov_s3_r <= ov_s2_r;
        end
    end

    // Per-bit agreement filter
    genvar gi;
    generate
        for (gi = 0; gi < n; gi++) begin : g_filter
            always_ff @(posedge i_core_clk or posedge i_reset) begin
                if (i_reset) begin
                    uv_flt_r[gi] <= 1'b0;
                    ov_flt_r[gi] <= 1'b0;
                end else begin
                    if (uv_s2_r[gi] == uv_s3_r[gi]) begin
                        uv_flt_r[gi] <= uv_s3_r[gi];
                    end
                    if (ov_s2_r[gi] == ov_s3_r[gi]) begin
                        ov_flt_r[gi] <= ov_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Power-good evaluation
    // ----------------------------------------------------------------
    // overvoltage counts only in window mode
    assign fault_nxt = enable_vec & (uv_flt_r | (ov_flt_r & {n{check_method_select}}));

    // Both outputs share the same verdict; both are high when good, low in reset and the load cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            fault_r <= '0;
            o_power_good_out_a <= 1'b0;
            o_power_good_out_b <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            o_power_good_out_a <= (state_r == cfg_run) && (fault_nxt == '0);
            o_power_good_out_b <= (state_r == cfg_run) && (fault_nxt == '0);
        end
    end

    // A config change can newly expose a fault, which then pulses here
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fault_event <= 1'b0;
        end else begin
            o_fault_event <= |(fault_nxt & ~fault_r);
        end
    end

    // ----------------------------------------------------------------
    // Monitor one analog settings
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_monitor_one_tolerance <= '0;
            o_monitor_one_level <= '0;
            o_monitor_one_divider_en <= 1'b0;
        end else begin
            o_monitor_one_tolerance <= level_r[tolerance_lsb +: tolerance_w];
            o_monitor_one_level <= level_r[level_lsb +: level_w];
            o_monitor_one_divider_en <=
                (level_r[level_lsb +: level_w] != level_external_divider);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_load_cycle;
        state_r == cfg_load_otp;
    endsequence

    sequence s_uv_stable;
        (i_uv_flags == $past(i_uv_flags)) [*4];
    endsequence

    property p_uv_only;
        (state_r == cfg_run && !check_method_select && (enable_vec & uv_flt_r) == '0)
            |=> o_power_good_out_a && o_power_good_out_b;
    endproperty
    a_uv_only: assert property (p_uv_only) else $error("ov fault seen in uv-only mode");

    property p_ov_counts;
        (check_method_select && (enable_vec & ov_flt_r) != '0) |=> !o_power_good_out_a;
    endproperty
    a_ov_counts: assert property (p_ov_counts) else $error("ov fault ignored in window mode");

    property p_event_on_new_fault;
        ((fault_nxt & ~fault_r) != '0) |=> o_fault_event ##1 (fault_r == $past(fault_nxt));
    endproperty
    a_event_on_new_fault: assert property (p_event_on_new_fault) else $error("event missed");

    property p_disabled_quiet;
        (state_r == cfg_run && ctrl_r[5:0] == '0) |=> o_power_good_out_b && !o_fault_event;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source acted");

    property p_first_buck_gate;
        (!first_buck_check_enable && uv_flt_r[first_buck_bit]) |-> !fault_nxt[first_buck_bit];
    endproperty
    a_first_buck_gate: assert property (p_first_buck_gate) else $error("buck fault leaked");

    property p_tolerance;
        ##1 o_monitor_one_tolerance == $past(level_r[tolerance_lsb +: tolerance_w]);
    endproperty
    a_tolerance: assert property (p_tolerance) else $error("tolerance output wrong");

    property p_level;
        ##1 o_monitor_one_level == $past(level_r[level_lsb +: level_w]);
    endproperty
    a_level: assert property (p_level) else $error("threshold output wrong");

    property p_divider;
        (level_r[2:0] == 3'h0) |=> !o_monitor_one_divider_en;
    endproperty
    a_divider: assert property (p_divider) else $error("divider on for code zero");

    property p_otp_load;
        s_load_cycle |=> (ctrl_r == ($past(i_otp_control_default) & 8'h7f))
            && (level_r == ($past(i_otp_levels_default) & 8'h1f));
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("defaults not loaded");

    property p_reserved_zero;
        ##1 (ctrl_r[7] == 1'b0) && (level_r[7:5] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_uv_filter;
        s_uv_stable |=> uv_flt_r == $past(i_uv_flags);
    endproperty
    a_uv_filter: assert property (p_uv_filter) else $error("input filter stuck");

endmodule : pg_monitor

`default_nettype wire

// *** verification/power_good_monitor_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module power_good_monitor_config_tb_top;
    import pg_monitor_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] otp_ctrl = 8'hff;
    logic [7:0] otp_lvl = 8'hff;
    logic [5:0] uv = 6'h00;
    logic [5:0] ov = 6'h00;
    logic [7:0] rdata;
    logic pg_a;
    logic pg_b;
    logic fault_ev;
    logic [1:0] tol;
    logic [2:0] lvl;
    logic div_en;
    logic [7:0] got;
    int bad_count = 0;
    int compares = 0;
    int events = 0;
    int e0 = 0;

    // 10 MHz core clock
    always #50 i_core_clk = ~i_core_clk;

    // Count fault pulses; seen value is the one launched by the previous edge
    always @(posedge i_core_clk) begin
        if (fault_ev === 1'b1) begin
            events <= events + 1;
        end
    end

    pg_monitor dut_u (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_reg_addr(addr),
        .i_reg_wdata(wdata),
        .i_reg_wr(wr),
        .i_reg_rd(rd),
        .o_reg_rdata(rdata),
        .i_otp_control_default(otp_ctrl),
        .i_otp_levels_default(otp_lvl),
        .i_uv_flags(uv),
        .i_ov_flags(ov),
        .o_power_good_out_a(pg_a),
        .o_power_good_out_b(pg_b),
        .o_fault_event(fault_ev),
        .o_monitor_one_tolerance(tol),
        .o_monitor_one_level(lvl),
        .o_monitor_one_divider_en(div_en)
    );

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : tick

    // One-cycle strobe; released on the edge that takes it
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_core_clk);
        wr <= 1'b0;
    endtask : reg_write

    // Data is registered, so look just after the taking edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Outputs are settled well past the five-edge comparator path
    task automatic check_pg(input logic exp);
        tick(8);
        #1;
        check("power good a", {7'h00, exp}, {7'h00, pg_a});
        check("power good b", {7'h00, exp}, {7'h00, pg_b});
    endtask : check_pg

    task automatic do_reset();
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        tick(5);
        #1;
        check("power good in reset", 8'h00, {6'h00, pg_a, pg_b});
        @(posedge i_core_clk);
        i_reset <= 1'b0;
        tick(3);
    endtask : do_reset

    task automatic close_out();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        reg_read(power_good_control_offset, got);
        check("control default", 8'h7f, got);
        reg_read(monitor_one_levels_offset, got);
        check("levels default", 8'h1f, got);
        check("settings default", 8'h3f, {2'h0, tol, lvl, div_en});
        // Second reset with a different default pattern
        @(posedge i_core_clk);
        otp_ctrl <= 8'h2a;
        otp_lvl <= 8'h0a;
        do_reset();
        reg_read(power_good_control_offset, got);
        check("control default 2", 8'h2a, got);
        reg_read(monitor_one_levels_offset, got);
        check("levels default 2", 8'h0a, got);
        // Reserved bits drop; unmapped place neither stores nor disturbs
        reg_write(power_good_control_offset, 8'h80);
        reg_read(power_good_control_offset, got);
        check("control reserved", 8'h00, got);
        reg_write(monitor_one_levels_offset, 8'he0);
        reg_read(monitor_one_levels_offset, got);
        check("levels reserved", 8'h00, got);
        reg_write(8'h15, 8'hff);
        reg_read(8'h15, got);
        check("unmapped read", 8'h00, got);
        reg_read(monitor_one_levels_offset, got);
        check("levels untouched", 8'h00, got);
        // Every tolerance and threshold code, each checked two edges after its write is taken
        for (int t = 0; t < 4; t++) begin
            for (int v = 0; v < 8; v++) begin
                reg_write(monitor_one_levels_offset, {3'h0, t[1:0], v[2:0]});
                tick(2);
                #1;
                check("tolerance", {6'h00, t[1:0]}, {6'h00, tol});
                check("level", {5'h00, v[2:0]}, {5'h00, lvl});
                check("divider", {7'h00, v != 0}, {7'h00, div_en});
            end
        end
        // One source enabled at a time; all the others faulted
        for (int i = 0; i < 6; i++) begin
            @(posedge i_core_clk);
            uv <= ~(6'h01 << i);
            ov <= 6'h00;
            reg_write(power_good_control_offset, 8'h01 << i);
            check_pg(1'b1);
            e0 = events;
            @(posedge i_core_clk);
            uv <= 6'h01 << i;
            check_pg(1'b0);
            check("fault pulses", 8'h01, 8'(events - e0));
        end
        // Overvoltage only counts when both checks are selected
        @(posedge i_core_clk);
        uv <= 6'h00;
        ov <= 6'h3f;
        reg_write(power_good_control_offset, 8'h3f);
        check_pg(1'b1);
        e0 = events;
        reg_write(power_good_control_offset, 8'h7f);
        check_pg(1'b0);
        check("config change pulse", 8'h01, 8'(events - e0));
        e0 = events;
        reg_write(power_good_control_offset, 8'h40);
        check_pg(1'b1);
        check("no fault when disabled", 8'h00, 8'(events - e0));
        close_out();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge i_core_clk);
        bad_count++;
        $display("FAIL run length expected finish seen timeout");
        close_out();
    end

endmodule : power_good_monitor_config_tb_top

`default_nettype wire
